// ---- dv/osc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module osc_model (
    input wire logic clk,
    input wire logic osc_stop,
    output logic osc_running
);
    int n = 0;
    initial osc_running = 1'b1;
    // restart some cycles after stop ends
    always @(posedge clk) begin
        n <= osc_stop ? 6 : (n > 0 ? n - 1 : 0);
        osc_running <= !osc_stop && n <= 1;
    end
endmodule
`default_nettype wire

// ---- dv/standby_wake_controller_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module standby_wake_controller_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic halt_exec,
    input wire logic stop_exec,
    input wire logic on_main_clock,
    input wire logic irq_pending,
    input wire logic nmi_req,
    input wire logic ack_enable_flag,
    input wire logic reset_req,
    input wire logic cpu_clk_en,
    input wire logic osc_stop,
    input wire logic standby_release,
    input wire logic resume_vector,
    input wire logic resume_next,
    input wire logic reset_resume
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_halt_gates_clk: assert property (halt_exec && cpu_clk_en && !irq_pending && !nmi_req && !reset_req |=> !cpu_clk_en) else $error("halt kept cpu clock");
    a_stop_main_only: assert property (stop_exec && !on_main_clock && !osc_stop |=> !osc_stop) else $error("stop taken off main clock");
    a_release_one: assert property (standby_release |=> !standby_release) else $error("release pulse too long");
    a_release_cause: assert property (standby_release |-> $past(!cpu_clk_en)) else $error("release outside standby");
    a_nmi_vectors: assert property ($rose(nmi_req) && !cpu_clk_en && !osc_stop |-> ##[1:14] resume_vector) else $error("nmi did not vector");
    a_irq_next: assert property ($rose(irq_pending) && !ack_enable_flag && !cpu_clk_en && !osc_stop |-> ##[1:14] resume_next) else $error("irq did not resume");
    a_next_alone: assert property (resume_next |-> !resume_vector && !reset_resume) else $error("resume kinds overlap");
    a_stop_holds: assert property (osc_stop && !irq_pending && !nmi_req && !reset_req |=> osc_stop) else $error("stop left without cause");
    a_reset_idle: assert property (disable iff (1'b0) !resetn |-> cpu_clk_en && !osc_stop) else $error("bad reset outputs");
    cover property (resume_vector);
    cover property (resume_next);
    cover property (osc_stop);
endmodule
bind standby_wake_controller standby_wake_controller_chk chk_inst (.*);
`default_nettype wire

// ---- dv/test_standby_wake_controller.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_standby_wake_controller;
    logic clk = 0, resetn = 1, reg_wr = 0, reg_bit_wr = 0, rd_go = 0;
    logic [1:0] reg_sel = 0;
    logic [2:0] reg_bit = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, key_pins = 8'hff;
    logic halt_exec = 0, stop_exec = 0, on_main_clock = 1, osc_running;
    logic osc_mode_select_bit = 1, watch_overflow_event = 0;
    logic irq_pending = 0, nmi_req = 0, ack_enable_flag = 0, reset_req = 0;
    logic cpu_clk_en, osc_stop, standby_release;
    logic resume_vector, resume_next, reset_resume;
    logic [7:0] exp_q[$], got;
    int fails = 0, n_checks = 0, cyc = 0, k;
    standby_wake_controller standby_wake_controller_inst (.*);
    osc_model osc_model_inst (.*);
    always #2 clk = ~clk;
    task automatic stop_test();
        if (fails == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // results are compared against the oldest note
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            stop_test();
        end
        got = rd_go ? reg_rdata : {5'h0, resume_vector, resume_next, reset_resume};
        if (rd_go || got != 0) begin
            n_checks++;
            if (exp_q.size() == 0 || exp_q[0] !== got) begin
                $display("MISMATCH %s exp %h got %h", rd_go ? "reg" : "resume", exp_q.size() ? exp_q[0] : 8'hxx, got);
                fails++;
            end
            if (exp_q.size()) void'(exp_q.pop_front());
        end
    end
    task automatic tick(int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic drain(int n);
        for (int i = 0; i < n && exp_q.size() > 0; i++) tick();
    endtask
    task automatic wr(logic [1:0] s, logic [7:0] d, logic bw = 0, logic [2:0] b = 0);
        reg_sel = s;
        reg_wdata = d;
        reg_bit = b;
        reg_wr = !bw;
        reg_bit_wr = bw;
        tick();
        reg_wr = 0;
        reg_bit_wr = 0;
        tick();
    endtask
    task automatic rd(logic [1:0] s, logic [7:0] e);
        reg_sel = s;
        tick();
        exp_q.push_back(e);
        rd_go = 1;
        tick();
        rd_go = 0;
    endtask
    task automatic enter(logic stop);
        halt_exec = !stop;
        stop_exec = stop;
        tick();
        halt_exec = 0;
        stop_exec = 0;
        tick(3);
    endtask
    task automatic wake(int src, logic [7:0] e);
        exp_q.push_back(e);
        nmi_req = src == 0;
        irq_pending = src == 1;
        reset_req = src == 3;
        watch_overflow_event = src == 2;
        tick();
        watch_overflow_event = 0;
        drain(6000);
        {nmi_req, irq_pending, reset_req} = 3'h0;
        tick(3);
    endtask
    initial begin
        void'($urandom(95));
        #1 resetn = 0;
        tick(4);
        resetn = 1;
        tick();
        rd(0, 8'h00);
        rd(1, 8'hff);
        rd(2, 8'h02);
        rd(3, 8'h04);
        wr(0, 8'hff);
        rd(0, 8'h87);
        wr(0, 8'h00);
        wr(1, 8'h00, 1, 0);
        rd(1, 8'hfe);
        watch_overflow_event = 1;
        tick();
        watch_overflow_event = 0;
        rd(0, 8'h01);
        wr(0, 8'h00);
        k = $urandom_range(7, 0);
        for (int en = 0; en < 2; en++) begin
            wr(2, 8'h02 | 8'(en));
            key_pins[k] = 0;
            tick();
            key_pins = 8'hff;
            rd(0, en ? 8'h02 : 8'h00);
        end
        rd(0, 8'h02);
        wr(0, 8'h00);
        enter(0);
        wake(0, 8'h04);
        ack_enable_flag = 1'($urandom);
        enter(0);
        wake(1, ack_enable_flag ? 8'h04 : 8'h02);
        ack_enable_flag = 0;
        enter(0);
        wake(2, 8'h02);
        wr(0, 8'h00);
        wr(1, 8'h01, 1, 0);
        enter(0);
        watch_overflow_event = 1;
        tick();
        watch_overflow_event = 0;
        tick(20);
        wake(0, 8'h04);
        wr(0, 8'h00);
        wr(3, 8'h00);
        rd(3, 8'h00);
        // request flags and settle select cleared, settle select read back before stop
        enter(1);
        wake(1, 8'h02);
        on_main_clock = 0;
        enter(1);
        on_main_clock = 1;
        enter(0);
        wake(3, 8'h01);
        if (exp_q.size()) fails++;
        stop_test();
    end
endmodule
`default_nettype wire

// ---- include/standby_pkg.sv ----
// Overview of operation
// - test event sets flag, releases, never vectors
// - two test sources: watch, key edge
// - watch overflow sets its test flag
// - any port-11 falling edge sets key flag while bit 0 of 02h is set
// - key return control resets 02h
// - halt gates cpu clock, oscillator runs
// - stop halts main oscillator
// - standby keeps registers and port state
// - stop only from main clock
// - settle select written as whole byte
// - reset 04h; reset-ended stop waits 2^17
// - settle count starts at oscillation start
// - count clock is fx or fx/2
// - unmasked interrupt ends halt, vectors if enabled
// - halt resume 8-9 or 2-3 clocks
// - nmi ends halt, vectors unless reset_req is also set
// - unmasked test input resumes next instruction
// - pending request at stop enters settle wait, oscillator kept running
// - stop release waits settle then resumes
// - reset in halt does reset processing
package standby_pkg;
    localparam logic [1:0] reg_req = 2'h0;
    localparam logic [1:0] reg_mask = 2'h1;
    localparam logic [1:0] reg_key = 2'h2;
    localparam logic [1:0] reg_settle = 2'h3;
    localparam int bit_watch = 0;
    localparam int bit_key = 1;
    localparam int key_enable_bit = 0;
    localparam logic [7:0] req_reset = 8'h00;
    localparam logic [7:0] mask_reset = 8'hff;
    localparam logic [7:0] key_reset = 8'h02;
    localparam logic [7:0] settle_reset = 8'h04;
    localparam logic [7:0] req_fixed_zero = 8'h78;
    localparam logic [4:0] reset_settle_exp = 5'h11;
    localparam logic [4:0] settle_exp_base = 5'h0e;
    localparam logic [3:0] vector_wait = 4'h8;
    localparam logic [3:0] next_wait = 4'h2;
endpackage

// ---- logic/standby_wake_controller.sv ----
`timescale 1ns/1ps
`default_nettype none
module standby_wake_controller (
    input wire logic clk,
    input wire logic resetn,
    input wire logic reg_wr,
    input wire logic reg_bit_wr,
    input wire logic [1:0] reg_sel,
    input wire logic [2:0] reg_bit,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic halt_exec,
    input wire logic stop_exec,
    input wire logic on_main_clock,
    input wire logic osc_running,
    input wire logic osc_mode_select_bit,
    input wire logic watch_overflow_event,
    input wire logic [7:0] key_pins,
    input wire logic irq_pending,
    input wire logic nmi_req,
    input wire logic ack_enable_flag,
    input wire logic reset_req,
    output logic cpu_clk_en,
    output logic osc_stop,
    output logic standby_release,
    output logic resume_vector,
    output logic resume_next,
    output logic reset_resume
);
    typedef enum logic [3:0] {
        st_run = 4'h1,
        st_halt = 4'h2,
        st_stop = 4'h4,
        st_wait = 4'h8
    } state_type;

    state_type state_r, state_nxt;
    logic [7:0] req_r, mask_r, key_r, settle_r, key_prev_r;
    logic [7:0] rdata_r;
    logic [17:0] cnt_r;
    logic [3:0] wait_r;
    logic halfclk_r, vec_r, from_reset_r, release_r, reset_hold_r;
    logic cpu_en_r, osc_stop_r, rv_r, rn_r, rr_r;

    // ------------------------------------------------------------
    // register access and event flags
    // ------------------------------------------------------------
    wire [7:0] bit_sel = 8'h01 << reg_bit;
    wire wr_req = (reg_wr | reg_bit_wr) && reg_sel == standby_pkg::reg_req;
    wire wr_mask = (reg_wr | reg_bit_wr) &&
        reg_sel == standby_pkg::reg_mask;
    wire wr_key = (reg_wr | reg_bit_wr) && reg_sel == standby_pkg::reg_key;
    wire wr_settle = reg_wr && reg_sel == standby_pkg::reg_settle;
    wire [7:0] req_wval = reg_wr ? reg_wdata :
        ((req_r & ~bit_sel) | (bit_sel & {8{reg_wdata[0]}}));
    wire [7:0] mask_wval = reg_wr ? reg_wdata :
        ((mask_r & ~bit_sel) | (bit_sel & {8{reg_wdata[0]}}));
    wire [7:0] key_wval = reg_wr ? reg_wdata :
        ((key_r & ~bit_sel) | (bit_sel & {8{reg_wdata[0]}}));
    // falling edge on any key pin
    wire key_fall = |(key_prev_r & ~key_pins) &&
        key_r[standby_pkg::key_enable_bit];
    wire [7:0] set_mask = ({7'h00, watch_overflow_event} <<
        standby_pkg::bit_watch) | ({7'h00, key_fall} << standby_pkg::bit_key);
    wire [7:0] req_nxt = ((wr_req ? req_wval : req_r) | set_mask) &
        ~standby_pkg::req_fixed_zero;
    wire test_wake = |(req_r & ~mask_r & 8'h03);
    wire any_wake = test_wake | irq_pending | nmi_req;
    wire vec_now = nmi_req | (irq_pending & ack_enable_flag);
    wire [7:0] rd_mux = reg_sel == standby_pkg::reg_req ? req_r :
        reg_sel == standby_pkg::reg_mask ? mask_r :
        reg_sel == standby_pkg::reg_key ? key_r : settle_r;

    wire [4:0] sel_exp = settle_r[2:0] == 3'h0 ? 5'h0c :
        5'(standby_pkg::settle_exp_base + 5'(settle_r[2:0]));
    // reset ending stop uses fixed count
    wire [4:0] use_exp = from_reset_r ? standby_pkg::reset_settle_exp :
        sel_exp;
    wire [17:0] settle_target = 18'(19'h00001 << use_exp) - 18'h1;
    wire tick = osc_mode_select_bit | halfclk_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            st_run: begin
                if (stop_exec && on_main_clock && !any_wake) begin
                    state_nxt = st_stop;
                end else if (stop_exec && on_main_clock) begin
                    state_nxt = st_wait;
                end else if (halt_exec) begin
                    state_nxt = st_halt;
                end
            end
            st_halt: if (any_wake || reset_req) state_nxt = st_run;
            st_stop: if (any_wake || reset_req) state_nxt = st_wait;
            st_wait: begin
                if (osc_running && tick && cnt_r >= settle_target) begin
                    state_nxt = st_run;
                end
            end
            default: state_nxt = st_run;
        endcase
    end

    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= st_run;
            req_r <= standby_pkg::req_reset;
            mask_r <= standby_pkg::mask_reset;
            key_r <= standby_pkg::key_reset;
            settle_r <= standby_pkg::settle_reset;
            key_prev_r <= 8'hff;
            rdata_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            req_r <= req_nxt;
            if (wr_mask) mask_r <= mask_wval | standby_pkg::req_fixed_zero;
            if (wr_key) key_r <= key_wval;
            if (wr_settle) settle_r <= reg_wdata;
            key_prev_r <= key_pins;
            rdata_r <= rd_mux;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 18'h0;
            halfclk_r <= 1'b0;
            from_reset_r <= 1'b0;
            vec_r <= 1'b0;
            wait_r <= 4'h0;
            release_r <= 1'b0;
            reset_hold_r <= 1'b0;
        end else begin
            halfclk_r <= ~halfclk_r;
            release_r <= state_r != st_run && state_nxt != state_r;
            if (state_r == st_stop || state_r == st_run) begin
                cnt_r <= 18'h0;
                from_reset_r <= reset_req && state_r == st_stop;
            end else if (state_r == st_wait && osc_running && tick) begin
                cnt_r <= 18'(cnt_r + 18'h1);
            end
            if (state_r != st_run && state_nxt == st_run) begin
                vec_r <= vec_now && !reset_req && !from_reset_r;
                reset_hold_r <= reset_req || from_reset_r;
                wait_r <= vec_now ? standby_pkg::vector_wait :
                    standby_pkg::next_wait;
            end else if (wait_r != 4'h0) begin
                wait_r <= 4'(wait_r - 4'h1);
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cpu_en_r <= 1'b1;
            osc_stop_r <= 1'b0;
            rv_r <= 1'b0;
            rn_r <= 1'b0;
            rr_r <= 1'b0;
        end else begin
            // clock gating and oscillator stop
            // cpu stays gated until the resume countdown ends
            cpu_en_r <= state_nxt == st_run && state_r == st_run &&
                wait_r <= 4'h1;
            osc_stop_r <= state_nxt == st_stop;
            rv_r <= wait_r == 4'h1 && vec_r;
            rn_r <= wait_r == 4'h1 && !vec_r && !reset_hold_r;
            rr_r <= wait_r == 4'h1 && reset_hold_r;
        end
    end

    assign reg_rdata = rdata_r;
    assign cpu_clk_en = cpu_en_r;
    assign osc_stop = osc_stop_r;
    assign standby_release = release_r;
    assign resume_vector = rv_r;
    assign resume_next = rn_r;
    assign reset_resume = rr_r;
endmodule
`default_nettype wire
